//--- hdl/adc_clock_gen.v
// Conversion clock tick generator: divided system clock or dedicated RC clock.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.vh"

module adc_clock_gen #(
  parameter DIV_W = 6
) (
  input  wire       clk_i,
  input  wire       sys_rst_i,
  input  wire       run_i,
  input  wire [2:0] clock_select_i,
  input  wire       rc_clock_i,
  output reg        half_tick_o
);

  reg  [DIV_W-1:0] div_q;
  reg  [DIV_W-1:0] div_d;
  reg  [DIV_W-1:0] limit;
  reg              rc_s1_q;
  reg              rc_s2_q;
  reg              rc_s3_q;

  // Half period is 2^code system clocks for codes 0..5, so fosc is divided by 2^(code+1); code 0 means divide by 2.
  always @* begin
    limit = {DIV_W{1'b0}};
    case (clock_select_i)
      3'h0:    limit = 6'd0;
      3'h1:    limit = 6'd1;
      3'h2:    limit = 6'd3;
      3'h3:    limit = 6'd7;
      3'h4:    limit = 6'd15;
      3'h5:    limit = 6'd31;
      default: limit = 6'd0;
    endcase
  end

  always @* begin
    div_d = div_q + 6'd1;
    if (!run_i || div_q >= limit) begin
      div_d = {DIV_W{1'b0}};
    end
  end

  // The RC clock is foreign; two flops settle it before the edge detector looks.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_q       <= {DIV_W{1'b0}};
      rc_s1_q     <= 1'b0;
      rc_s2_q     <= 1'b0;
      rc_s3_q     <= 1'b0;
      half_tick_o <= 1'b0;
    end else begin
      div_q   <= div_d;
      rc_s1_q <= rc_clock_i;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
      if (clock_select_i == `CS_RC) begin
        half_tick_o <= run_i & (rc_s2_q ^ rc_s3_q);
      end else begin
        half_tick_o <= run_i & (div_q >= limit);
      end
    end
  end

endmodule // adc_clock_gen
`default_nettype wire

//--- hdl/adc_ctrl.v
// Converter control, Wishbone register file and successive-approximation sequencer.
// Functional notes
// - The channel select field picks the one input fed to sample-and-hold.
// - Positive reference comes from pin, supply rail or fixed-reference buffer.
// - Negative reference is always ground; no field selects it.
// - Conversion clock is fosc divided by 2..64 or the RC clock.
// - A 10-bit conversion takes 11.5 bit-conversion periods.
// - Divided clocks follow the system clock; only RC stays independent.
// - Right-justified: top two result bits in high register bits 1:0.
// - Right-justified: low eight result bits in the low result register.
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.vh"

module adc_ctrl #(
  parameter RES_W = 10
) (
  input  wire        clk_i,
  input  wire        sys_rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        rc_clock_i,
  input  wire        comparator_i,
  output reg  [3:0]  channel_select_o,
  output reg  [1:0]  positive_ref_select_o,
  output wire        negative_ref_ground_o,
  output reg         sample_hold_o,
  output reg  [9:0]  dac_trial_o,
  output reg         irq_o
);

  reg  [7:0]       ctrl0_q;
  reg  [7:0]       ctrl1_q;
  reg  [RES_W-1:0] result_q;
  reg  [RES_W-1:0] sar_q;
  reg  [4:0]       half_cnt_q;
  reg  [1:0]       state_q;
  reg  [7:0]       res_high;
  reg  [7:0]       res_low;
  reg  [31:0]      rd_data;
  wire             half_tick;
  wire             wr_en;
  wire             rd_req;
  wire             conv_done;
  wire [3:0]       bit_idx;
  wire             trial_phase;
  wire             compare_phase;

  // Sequencer states; the unused code falls back to idle.
  localparam ST_IDLE   = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_CONV   = 2'h2;

  // The tick generator clears its divider while the sequencer is idle, so each conversion on a divided clock starts on a whole period.
  adc_clock_gen #(
    .DIV_W (6)
  ) u_clock_gen (
    .clk_i          (clk_i),
    .sys_rst_i      (sys_rst_i),
    .run_i          (state_q != ST_IDLE),
    .clock_select_i (ctrl1_q[`CTRL1_CS_MSB:`CTRL1_CS_LSB]),
    .rc_clock_i     (rc_clock_i),
    .half_tick_o    (half_tick)
  );

  // The registered ack masks a held request in its answer cycle, so no access is taken twice.
  assign wr_en  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign rd_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  assign negative_ref_ground_o = 1'b1;

  // Half periods 0..1 sample, then pair n (n = 1..10) resolves bit 10 - n, msb first.
  assign bit_idx       = 4'd10 - half_cnt_q[4:1];
  // A trial word is shown for a whole bit period and judged at the end of its second half.
  assign trial_phase   = (state_q == ST_CONV) && (half_cnt_q >= 5'h02) && (half_cnt_q <= 5'h15);
  assign compare_phase = trial_phase && half_cnt_q[0];
  // The last half period resolves no bit; it only closes the conversion.
  // 11.5 bit periods long
  assign conv_done     = (state_q == ST_CONV) && half_tick && (half_cnt_q == `CONV_HALF_PERIODS - 5'd1);

  always @* begin
    if (ctrl1_q[`CTRL1_FMT_BIT]) begin
      res_high = {6'h00, result_q[9:8]};
      res_low  = result_q[7:0];
    end else begin
      // Left-justified: the top eight bits in the high register, the last two at the top of the low one.
      res_high = result_q[9:2];
      res_low  = {result_q[1:0], 6'h00};
    end
  end

  always @* begin
    // Unmapped addresses read as zero.
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      `ADDR_CTRL0:    rd_data = {24'h00_0000, ctrl0_q};
      `ADDR_CTRL1:    rd_data = {24'h00_0000, ctrl1_q};
      `ADDR_RES_HIGH: rd_data = {24'h00_0000, res_high};
      `ADDR_RES_LOW:  rd_data = {24'h00_0000, res_low};
      default:        rd_data = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl0_q    <= `CTRL0_RESET;
      ctrl1_q    <= `CTRL1_RESET;
      result_q   <= {RES_W{1'b0}};
      sar_q      <= {RES_W{1'b0}};
      half_cnt_q <= 5'h00;
      state_q    <= ST_IDLE;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
    end else begin
      wb_ack_o <= rd_req;
      if (rd_req) begin
        wb_dat_o <= rd_data;
      end
      if (wr_en) begin
        case (wb_adr_i)
          `ADDR_CTRL0: begin
            ctrl0_q[`CTRL0_ON_BIT]                     <= wb_dat_i[`CTRL0_ON_BIT];
            ctrl0_q[`CTRL0_CHS_MSB:`CTRL0_CHS_LSB]     <= wb_dat_i[`CTRL0_CHS_MSB:`CTRL0_CHS_LSB];
            ctrl0_q[`CTRL0_IEN_BIT]                    <= wb_dat_i[`CTRL0_IEN_BIT];
            // Writing zero clears the done flag; a completion in this cycle wins below.
            if (!wb_dat_i[`CTRL0_DONE_BIT]) begin
              ctrl0_q[`CTRL0_DONE_BIT] <= 1'b0;
            end
            if (wb_dat_i[`CTRL0_START_BIT] && ctrl0_q[`CTRL0_ON_BIT] && state_q == ST_IDLE) begin
              ctrl0_q[`CTRL0_START_BIT] <= 1'b1;
            end
          end
          `ADDR_CTRL1:    ctrl1_q <= {wb_dat_i[7:4], 2'b00, wb_dat_i[1:0]};
          // The result registers stay writable; the next completion overwrites them.
          `ADDR_RES_HIGH: result_q[9:8] <= wb_dat_i[1:0];
          `ADDR_RES_LOW:  result_q[7:0] <= wb_dat_i[7:0];
          default:        ;
        endcase
      end
      case (state_q)
        ST_IDLE: begin
          half_cnt_q <= 5'h00;
          // A new start clears the previous trial bits.
          if (ctrl0_q[`CTRL0_START_BIT]) begin
            state_q <= ST_SAMPLE;
            sar_q   <= {RES_W{1'b0}};
          end
        end
        ST_SAMPLE: begin
          state_q <= ST_CONV;
          // Clearing the enable before the first tick drops the request as well.
          if (!ctrl0_q[`CTRL0_ON_BIT]) begin
            ctrl0_q[`CTRL0_START_BIT] <= 1'b0;
            state_q                   <= ST_IDLE;
          end
        end
        ST_CONV: begin
          if (half_tick) begin
            half_cnt_q <= half_cnt_q + 5'h01;
            // Compare on the second half of each bit period.
            if (compare_phase) begin
              sar_q[bit_idx] <= comparator_i;
            end
          end
          if (conv_done) begin
            result_q                  <= sar_q;
            ctrl0_q[`CTRL0_DONE_BIT]  <= 1'b1;
            ctrl0_q[`CTRL0_START_BIT] <= 1'b0;
            state_q                   <= ST_IDLE;
          end
          if (!ctrl0_q[`CTRL0_ON_BIT]) begin
            ctrl0_q[`CTRL0_START_BIT] <= 1'b0;
            state_q                   <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Trial word: resolved bits so far plus the bit under test.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      channel_select_o      <= 4'h0;
      positive_ref_select_o <= `PREF_VDD;
      sample_hold_o         <= 1'b0;
      dac_trial_o           <= 10'h000;
      irq_o                 <= 1'b0;
    end else begin
      channel_select_o      <= ctrl0_q[`CTRL0_CHS_MSB:`CTRL0_CHS_LSB];
      positive_ref_select_o <= ctrl1_q[`CTRL1_PREF_MSB:`CTRL1_PREF_LSB];
      // Sample-and-hold tracks the input for the first bit period, while the trial word stays zero.
      sample_hold_o         <= (state_q == ST_CONV) && (half_cnt_q < 5'h02);
      if (trial_phase) begin
        dac_trial_o <= sar_q | (10'h001 << bit_idx);
      end else begin
        dac_trial_o <= 10'h000;
      end
      // The request is a level; it falls once software clears the done flag.
      // interrupt request
      irq_o <= ctrl0_q[`CTRL0_DONE_BIT] & ctrl0_q[`CTRL0_IEN_BIT];
    end
  end

endmodule // adc_ctrl
`default_nettype wire

//--- hdl/adc_ctrl_map.vh
// Register offsets, field positions, reset values and timing counts of the converter control block.
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

// Byte addresses of the 32-bit register words.
`define ADDR_CTRL0      4'h0
`define ADDR_CTRL1      4'h4
`define ADDR_RES_HIGH   4'h8
`define ADDR_RES_LOW    4'hc

// Control register 0 fields.
`define CTRL0_START_BIT 0
`define CTRL0_ON_BIT    1
`define CTRL0_CHS_LSB   2
`define CTRL0_CHS_MSB   5
`define CTRL0_DONE_BIT  6
`define CTRL0_IEN_BIT   7

// Control register 1 fields.
`define CTRL1_PREF_LSB  0
`define CTRL1_PREF_MSB  1
`define CTRL1_CS_LSB    4
`define CTRL1_CS_MSB    6
`define CTRL1_FMT_BIT   7

// Reset values.
`define CTRL0_RESET     8'h00
`define CTRL1_RESET     8'h00

// Positive reference codes.
`define PREF_VDD        2'h0
`define PREF_PIN        2'h2
`define PREF_FIXED      2'h3

// Conversion clock code selecting the dedicated RC clock.
`define CS_RC           3'h7

// Conversion length in half bit periods: 11.5 periods.
`define CONV_HALF_PERIODS 5'h17

`endif

//--- verification/adc_analog_model.sv
// Behavioural analog side: per-channel input levels and the comparator.
`timescale 1ns/1ps
`default_nettype none
module adc_analog_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] channel_select_i,
  input  wire logic       sample_hold_i,
  input  wire logic [9:0] dac_trial_i,
  output logic            comparator_o
);
  logic [9:0] held_q = 10'h000;
  always @(posedge clk_i) begin
    if (sample_hold_i) begin
      held_q <= {channel_select_i[1:0], channel_select_i, channel_select_i};
    end
  end
  // Levels sit exactly on their code; a trial word equal to the level compares high.
  // compare against the trial word
  assign comparator_o = held_q >= dac_trial_i;
endmodule // adc_analog_model
`default_nettype wire

//--- verification/adc_ctrl_assertions.sv
// Port-level assertions for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_assertions (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic       wb_ack_o,
  input wire logic       irq_o,
  input wire logic       negative_ref_ground_o,
  input wire logic       sample_hold_o,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [3:0] channel_select_o,
  input wire logic [1:0] positive_ref_select_o,
  input wire logic [9:0] dac_trial_o
);
  wire wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  wire wr0 = wr && wb_adr_i == 4'h0;
  wire wr1 = wr && wb_adr_i == 4'h4;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  chk_neg_ground: assert property (negative_ref_ground_o) else $error("ref not ground");
  chk_chan_src: assert property (!$stable(channel_select_o) |-> $past(wr0) || $past(wr0, 2) || $past(wr0, 3))
    else $error("channel moved");
  chk_pref_src: assert property (!$stable(positive_ref_select_o) |-> $past(wr1) || $past(wr1, 2) || $past(wr1, 3))
    else $error("ref moved");
  chk_dac_zero: assert property (sample_hold_o |-> dac_trial_o == 10'h000) else $error("trial in acquire");
  chk_hold_len: assert property ($rose(sample_hold_o) |-> sample_hold_o [*2]) else $error("acquire short");
  chk_irq_keep: assert property (irq_o && !wr0 && !$past(wr0) |=> irq_o) else $error("done lost");
endmodule // adc_ctrl_assertions
bind adc_ctrl adc_ctrl_assertions adc_ctrl_assertions_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
  .negative_ref_ground_o(negative_ref_ground_o), .sample_hold_o(sample_hold_o), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .channel_select_o(channel_select_o), .positive_ref_select_o(positive_ref_select_o),
  .dac_trial_o(dac_trial_o));
`default_nettype wire

//--- verification/adc_ctrl_tb_top.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_tb_top;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, rc = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        ack, cmp, nref, sh, irq;
  logic [3:0]  adr = 4'h0, sel = 4'h0, channel_select_field, ch;
  logic [1:0]  pref, p;
  logic [9:0]  trial, code;
  logic [31:0] wd = 32'h0, rd, d;
  int          num_errors = 0, tests_run = 0, cnt = 0, ta, t0, n, lo, hi;
  always #20 clk_i = ~clk_i;
  // Slow and off-phase so the synchroniser never misses an edge.
  always #97 rc = ~rc;
  always @(posedge clk_i) cnt <= cnt + 1;
  adc_ctrl adc_ctrl_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .rc_clock_i(rc),
    .comparator_i(cmp), .channel_select_o(channel_select_field), .positive_ref_select_o(pref), .negative_ref_ground_o(nref),
    .sample_hold_o(sh), .dac_trial_o(trial), .irq_o(irq));
  adc_analog_model adc_analog_model_inst (.clk_i(clk_i), .channel_select_i(channel_select_field), .sample_hold_i(sh),
    .dac_trial_i(trial), .comparator_o(cmp));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", s, e, g);
      num_errors++;
    end
  endtask
  // Request rises after an edge, holds until ack is sampled high at a rising edge, takes the data and is
  // released at that edge; the caller resumes at the following falling edge, where outputs have settled.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= v;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    d = rd;
    ta = cnt;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // The whole run needs under 3000 cycles; the limit leaves ample room.
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    chk("ctrl1 reset", 32'h0, d);
    chk("neg ref", 32'h1, {31'h0, nref});
    bus(1'b1, 4'h4, 32'h83, 4'he);
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    chk("lane masked", 32'h0, d);
    bus(1'b1, 4'h2, 32'hff, 4'hf);
    bus(1'b0, 4'h2, 32'h0, 4'hf);
    chk("unmapped", 32'h0, d);
    for (int i = 0; i < 8; i++) begin
      ch = {i[2:0], 1'b1};
      code = {ch[1:0], ch, ch};
      p = (i % 3 == 0) ? 2'h0 : (i % 3 == 1) ? 2'h2 : 2'h3;
      bus(1'b1, 4'h4, {24'h0, 1'b1, i[2:0], 2'h0, p}, 4'h1);
      chk("ref select", {30'h0, p}, {30'h0, pref});
      bus(1'b1, 4'h0, {24'h0, 2'h2, ch, 2'h2}, 4'h1);
      chk("channel", {28'h0, ch}, {28'h0, channel_select_field});
      repeat (8) @(negedge clk_i);
      bus(1'b1, 4'h0, {24'h0, 2'h2, ch, 2'h3}, 4'h1);
      t0 = ta;
      bus(1'b0, 4'h0, 32'h0, 4'hf);
      chk("start held", 32'h1, d & 32'h1);
      while (irq !== 1'b1) @(negedge clk_i);
      n = cnt - t0;
      lo = (i == 7) ? 46 : 23 << (i % 6);
      hi = (i == 7) ? 86 : (26 << (i % 6)) + 8;
      chk("conv time", 32'h1, {31'h0, n >= lo && n <= hi});
      bus(1'b0, 4'h0, 32'h0, 4'hf);
      chk("ctrl0 done", {24'h0, 2'h3, ch, 2'h2}, d);
      bus(1'b0, 4'h8, 32'h0, 4'hf);
      chk("result high", {30'h0, code[9:8]}, d);
      bus(1'b0, 4'hc, 32'h0, 4'hf);
      chk("result low", {24'h0, code[7:0]}, d);
      bus(1'b1, 4'h0, {24'h0, 2'h2, ch, 2'h2}, 4'h1);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
    // Left-justified view of the last result, 10'h3ff; divide-by-2 clock and supply reference.
    bus(1'b1, 4'h4, 32'h0000_0000, 4'h1);
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    chk("left high", 32'hff, d);
    bus(1'b0, 4'hc, 32'h0, 4'hf);
    chk("left low", 32'hc0, d);
    // With the converter off, a start request is refused.
    bus(1'b1, 4'h0, 32'h0000_0000, 4'h1);
    bus(1'b1, 4'h0, 32'h0000_0001, 4'h1);
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    chk("start refused", 32'h0, d);
    // Channel 0 with the interrupt disabled: the flag is set but no request follows.
    bus(1'b1, 4'h0, 32'h0000_0002, 4'h1);
    repeat (8) @(negedge clk_i);
    bus(1'b1, 4'h0, 32'h0000_0003, 4'h1);
    repeat (40) @(negedge clk_i);
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    chk("done no irq", 32'h42, d);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    chk("zero result", 32'h0, d);
    test_done();
  end
endmodule // adc_ctrl_tb_top
`default_nettype wire
